/* pfc_pkg.sv */
// package: constants for the dual-slope frequency-correct pwm block
package pfc_pkg;
    // ========================================
    // waveform modes
    localparam logic [3:0] PFC_MODE_CAPTOP = 4'h8;
    localparam logic [3:0] PFC_MODE_CMPTOP = 4'h9;
    // ========================================
    // output mode field values
    localparam logic [1:0] PFC_COM_OFF = 2'h0;
    localparam logic [1:0] PFC_COM_TOGGLE = 2'h1;
    localparam logic [1:0] PFC_COM_NONINV = 2'h2;
    localparam logic [1:0] PFC_COM_INV = 2'h3;
    // ========================================
    // counter constants
    localparam logic [15:0] PFC_BOTTOM = 16'h0000;
    localparam logic [15:0] PFC_MIN_TOP = 16'h0003;
    // ========================================
    // prescaler select codes and divider masks
    localparam logic [2:0] PFC_CS_STOP = 3'h0;
    localparam logic [2:0] PFC_CS_DIV1 = 3'h1;
    localparam logic [2:0] PFC_CS_DIV8 = 3'h2;
    localparam logic [2:0] PFC_CS_DIV64 = 3'h3;
    localparam logic [2:0] PFC_CS_DIV256 = 3'h4;
    localparam logic [2:0] PFC_CS_DIV1024 = 3'h5;
    localparam logic [9:0] PFC_PRE_MASK8 = 10'h007;
    localparam logic [9:0] PFC_PRE_MASK64 = 10'h03f;
    localparam logic [9:0] PFC_PRE_MASK256 = 10'h0ff;
    localparam logic [9:0] PFC_PRE_MASK1024 = 10'h3ff;
    // ========================================
    // register offsets
    localparam logic [3:0] PFC_REG_CTRL = 4'h0;
    localparam logic [3:0] PFC_REG_COUNT = 4'h1;
    localparam logic [3:0] PFC_REG_CMPA = 4'h2;
    localparam logic [3:0] PFC_REG_CMPB = 4'h3;
    localparam logic [3:0] PFC_REG_CAPTOP = 4'h4;
    localparam logic [3:0] PFC_REG_STATUS = 4'h5;
    localparam logic [3:0] PFC_REG_MASK = 4'h6;
    localparam logic [3:0] PFC_REG_PIN = 4'h7;
    // ========================================
    // control register fields
    localparam int PFC_CTRL_MODE_LSB = 0;
    localparam int PFC_CTRL_CS_LSB = 4;
    localparam int PFC_CTRL_COMA_LSB = 8;
    localparam int PFC_CTRL_COMB_LSB = 10;
    // status fields
    localparam int PFC_ST_OVF = 0;
    localparam int PFC_ST_CMPA = 1;
    localparam int PFC_ST_CMPB = 2;
    localparam int PFC_ST_CAP = 3;
    localparam int PFC_ST_W = 4;
endpackage : pfc_pkg

/* pfc_pwm.sv */
// module: phase and frequency correct pwm timer with register port
// ========================================
module pfc_pwm
    import pfc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic chan_a_wave_out,
    output logic chan_a_wave_oe,
    output logic chan_b_wave_out,
    output logic chan_b_wave_oe,
    output logic irq
);
    // ========================================
    // registers
    logic [3:0] waveform_mode_sel;
    logic [2:0] clk_sel;
    logic [1:0] chan_a_output_mode;
    logic [1:0] chan_b_output_mode;
    logic [CNT_W-1:0] count_value;
    logic count_down;
    logic [CNT_W-1:0] chan_a_compare_value;
    logic [CNT_W-1:0] chan_b_compare_value;
    logic [CNT_W-1:0] chan_a_buffer;
    logic [CNT_W-1:0] chan_b_buffer;
    logic [CNT_W-1:0] capture_top_value;
    logic [PFC_ST_W-1:0] status;
    logic [PFC_ST_W-1:0] irq_mask;
    logic [1:0] pin_direction_bit;
    logic chan_a_state;
    logic chan_b_state;
    logic [9:0] pre_cnt;
    logic timer_tick_enable;
    logic pwm_on;
    logic [CNT_W-1:0] top_value;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic match_slope;
    logic [PFC_ST_W-1:0] events;
    logic [PFC_ST_W-1:0] w1c;

    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // next pwm output level on a match, by field and slope
    function automatic logic pwm_next(input logic [1:0] com, input logic cur, input logic down,
                                      input logic allow_tog);
        logic r;
        r = cur;
        case (com)
            PFC_COM_NONINV: r = down;
            PFC_COM_INV: r = ~down;
            PFC_COM_TOGGLE: r = allow_tog ? ~cur : cur;
            default: r = cur;
        endcase
        return r;
    endfunction

    // ========================================
    // prescaler and tick enable
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= 10'h000;
        end else if (clk_sel == PFC_CS_STOP) begin
            pre_cnt <= 10'h000;
        end else begin
            pre_cnt <= pre_cnt + 10'h001;
        end
    end

    always_comb begin
        case (clk_sel)
            PFC_CS_DIV1: timer_tick_enable = 1'b1;
            PFC_CS_DIV8: timer_tick_enable = (pre_cnt & PFC_PRE_MASK8) == PFC_PRE_MASK8;
            PFC_CS_DIV64: timer_tick_enable = (pre_cnt & PFC_PRE_MASK64) == PFC_PRE_MASK64;
            PFC_CS_DIV256: timer_tick_enable = (pre_cnt & PFC_PRE_MASK256) == PFC_PRE_MASK256;
            PFC_CS_DIV1024: timer_tick_enable = (pre_cnt & PFC_PRE_MASK1024) == PFC_PRE_MASK1024;
            default: timer_tick_enable = 1'b0;
        endcase
    end

    // ========================================
    // top select and compare decode
    assign pwm_on = (waveform_mode_sel == PFC_MODE_CAPTOP) || (waveform_mode_sel == PFC_MODE_CMPTOP);
    assign top_value = (waveform_mode_sel == PFC_MODE_CMPTOP) ? chan_a_compare_value
                                                              : capture_top_value;
    assign at_top = pwm_on && timer_tick_enable && (count_value == top_value);
    assign at_bottom = pwm_on && timer_tick_enable && (count_value == PFC_BOTTOM) && count_down;
    assign match_a = pwm_on && timer_tick_enable && (count_value == chan_a_compare_value);
    assign match_b = pwm_on && timer_tick_enable && (count_value == chan_b_compare_value);
    // slope that follows this tick: a top match leads down, a bottom match leads up
    assign match_slope = (count_value == top_value) ? 1'b1 : (count_value == PFC_BOTTOM) ? 1'b0 : count_down;

    // ========================================
    // up/down counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_value <= PFC_BOTTOM;
            count_down <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, PFC_REG_COUNT)) begin
            count_value <= reg_wdata[CNT_W-1:0];
        end else if (pwm_on && timer_tick_enable) begin
            if (!count_down) begin
                if (count_value == top_value) begin
                    count_down <= 1'b1;
                    count_value <= count_value - 16'h0001;
                end else begin
                    count_value <= count_value + 16'h0001;
                end
            end else if (count_value == PFC_BOTTOM) begin
                count_down <= 1'b0;
                count_value <= count_value + 16'h0001;
            end else begin
                count_value <= count_value - 16'h0001;
            end
        end
    end

    // ========================================
    // double-buffered compare registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_a_buffer <= 16'h0000;
            chan_b_buffer <= 16'h0000;
            chan_a_compare_value <= 16'h0000;
            chan_b_compare_value <= 16'h0000;
        end else begin
            if (reg_wr && wr_hit(reg_addr, PFC_REG_CMPA)) begin
                chan_a_buffer <= reg_wdata;
            end
            if (reg_wr && wr_hit(reg_addr, PFC_REG_CMPB)) begin
                chan_b_buffer <= reg_wdata;
            end
            if (!pwm_on) begin
                chan_a_compare_value <= chan_a_buffer;
                chan_b_compare_value <= chan_b_buffer;
            end else if (at_bottom) begin
                chan_a_compare_value <= chan_a_buffer;
                chan_b_compare_value <= chan_b_buffer;
            end
        end
    end

    // ========================================
    // control and capture top registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waveform_mode_sel <= 4'h0;
            clk_sel <= PFC_CS_STOP;
            chan_a_output_mode <= PFC_COM_OFF;
            chan_b_output_mode <= PFC_COM_OFF;
            capture_top_value <= 16'h0000;
            irq_mask <= '0;
            pin_direction_bit <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                PFC_REG_CTRL: begin
                    waveform_mode_sel <= reg_wdata[PFC_CTRL_MODE_LSB +: 4];
                    clk_sel <= reg_wdata[PFC_CTRL_CS_LSB +: 3];
                    chan_a_output_mode <= reg_wdata[PFC_CTRL_COMA_LSB +: 2];
                    chan_b_output_mode <= reg_wdata[PFC_CTRL_COMB_LSB +: 2];
                end
                PFC_REG_CAPTOP: capture_top_value <= reg_wdata;
                PFC_REG_MASK: irq_mask <= reg_wdata[PFC_ST_W-1:0];
                PFC_REG_PIN: pin_direction_bit <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // flags: set wins over write-one-clear
    always_comb begin
        events = '0;
        events[PFC_ST_OVF] = at_bottom;
        events[PFC_ST_CMPA] = match_a;
        events[PFC_ST_CMPB] = match_b;
        events[PFC_ST_CAP] = at_top && (waveform_mode_sel == PFC_MODE_CAPTOP);
    end
    assign w1c = (reg_wr && wr_hit(reg_addr, PFC_REG_STATUS)) ? reg_wdata[PFC_ST_W-1:0] : '0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
        end else begin
            status <= (status & ~w1c) | events;
        end
    end
    assign irq = |(status & irq_mask);

    // ========================================
    // waveform outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_a_state <= 1'b0;
            chan_b_state <= 1'b0;
        end else begin
            if (!pwm_on || chan_a_output_mode == PFC_COM_OFF) begin
                chan_a_state <= 1'b0;
            end else if (match_a) begin
                // extremes: bottom match counts as upcount, top match as downcount
                chan_a_state <= pwm_next(chan_a_output_mode, chan_a_state, match_slope,
                                         waveform_mode_sel == PFC_MODE_CMPTOP);
            end
            if (!pwm_on || chan_b_output_mode == PFC_COM_OFF) begin
                chan_b_state <= 1'b0;
            end else if (match_b) begin
                chan_b_state <= pwm_next(chan_b_output_mode, chan_b_state, match_slope, 1'b0);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_a_wave_out <= 1'b0;
            chan_b_wave_out <= 1'b0;
        end else begin
            chan_a_wave_out <= chan_a_state;
            chan_b_wave_out <= chan_b_state;
        end
    end
    assign chan_a_wave_oe = pin_direction_bit[0];
    assign chan_b_wave_oe = pin_direction_bit[1];

    // ========================================
    // register read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                PFC_REG_CTRL: reg_rdata <= {4'h0, chan_b_output_mode, chan_a_output_mode, 1'b0, clk_sel,
                                            waveform_mode_sel};
                PFC_REG_COUNT: reg_rdata <= count_value;
                PFC_REG_CMPA: reg_rdata <= chan_a_buffer;
                PFC_REG_CMPB: reg_rdata <= chan_b_buffer;
                PFC_REG_CAPTOP: reg_rdata <= capture_top_value;
                PFC_REG_STATUS: reg_rdata <= {12'h000, status};
                PFC_REG_MASK: reg_rdata <= {12'h000, irq_mask};
                PFC_REG_PIN: reg_rdata <= {14'h0000, pin_direction_bit};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ========================================
    // checks
    AST_MODE_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
        !pwm_on |=> $stable(count_value) || $past(reg_wr)) else $error("counter moved outside pwm mode");
    AST_TOP_TURN: assert property (@(posedge core_clk) disable iff (!nrst)
        (at_top && !count_down && !reg_wr) |=> count_down) else $error("no reversal at top");
    AST_TOP_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
        (pwm_on && !count_down && count_value == top_value && !timer_tick_enable && !reg_wr)
        |=> count_value == $past(count_value)) else $error("top not held until tick");
    AST_BOTTOM_RELOAD: assert property (@(posedge core_clk) disable iff (!nrst)
        at_bottom |=> status[PFC_ST_OVF] && chan_a_compare_value == $past(chan_a_buffer))
        else $error("bottom reload or overflow missing");
    AST_CMP_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
        match_b |=> status[PFC_ST_CMPB]) else $error("compare flag not set");
    AST_CAP_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
        (at_top && waveform_mode_sel == PFC_MODE_CAPTOP) |=> status[PFC_ST_CAP]) else $error("capture flag missed");
    AST_UP_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
        (match_b && !count_down && count_value != top_value && chan_b_output_mode == PFC_COM_NONINV)
        |=> ##1 !chan_b_wave_out)
        else $error("upcount match did not clear");
    AST_TOP_HIGH: assert property (@(posedge core_clk) disable iff (!nrst)
        (match_b && count_value == top_value && chan_b_output_mode == PFC_COM_NONINV) |=> ##1 chan_b_wave_out)
        else $error("compare at top did not drive high");
    AST_PIN_DIR: assert property (@(posedge core_clk) disable iff (!nrst)
        !pin_direction_bit[0] |-> !chan_a_wave_oe) else $error("pin driven while input");
    AST_BUF_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
        (pwm_on && reg_wr && reg_addr == PFC_REG_CMPB && !at_bottom) |=> $stable(chan_b_compare_value))
        else $error("compare written directly");
endmodule : pfc_pwm

/* pfc_load.sv */
// partner: load on one compare pin, resolves the pin level and measures pulse widths
module pfc_load (
    input wire logic core_clk,
    input wire logic drv,
    input wire logic oe,
    output logic pin_lvl,
    output int hi_len,
    output int lo_len,
    output int edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    int run = 0;
    // an undriven pin falls to the pull-down level of the load
    assign pin_lvl = oe ? drv : 1'b0;
    initial begin
        hi_len = 0;
        lo_len = 0;
        edges = 0;
    end
    // ========================================
    // run length of each level, in core clock cycles
    always @(posedge core_clk) begin
        if (pin_lvl !== last) begin
            if (last)
                hi_len <= run;
            else
                lo_len <= run;
            run <= 1;
            edges <= edges + 1;
        end else begin
            run <= run + 1;
        end
        last <= pin_lvl;
    end
endmodule // pfc_load

/* dual_slope_freq_correct_pwm_tb.sv */
// testbench: self-checking bench for the dual-slope frequency-correct pwm timer
module dual_slope_freq_correct_pwm_tb
    import pfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // signals
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic a_out, a_oe, b_out, b_oe, irq, a_pin, b_pin;
    int a_hi, a_lo, a_edges, b_hi, b_lo, b_edges;
    int error_cnt = 0;
    int check_count = 0;
    int div_tab[5] = '{1, 8, 64, 256, 1024};
    logic [31:0] lfsr = 32'h0001_6434;
    int m_cnt;
    bit m_up;
    always #50 core_clk = ~core_clk;
    pfc_pwm #(.CNT_W(16)) i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_a_wave_out(a_out), .chan_a_wave_oe(a_oe),
        .chan_b_wave_out(b_out), .chan_b_wave_oe(b_oe), .irq(irq));
    pfc_load i_load_a (.core_clk(core_clk), .drv(a_out), .oe(a_oe), .pin_lvl(a_pin), .hi_len(a_hi),
        .lo_len(a_lo), .edges(a_edges));
    pfc_load i_load_b (.core_clk(core_clk), .drv(b_out), .oe(b_oe), .pin_lvl(b_pin), .hi_len(b_hi),
        .lo_len(b_lo), .edges(b_edges));
    // ========================================
    // bus, compare and model tasks
    task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] addr, output logic [15:0] data);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        data = reg_rdata;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t value got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            error_cnt++;
            $display("ERROR %0t width got %0d expected %0d", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction
    // one timer tick of the reference counter
    task automatic model_tick(input int top);
        if (m_up && m_cnt == top)
            m_up = 1'b0;
        else if (!m_up && m_cnt == 0)
            m_up = 1'b1;
        m_cnt = m_up ? m_cnt + 1 : m_cnt - 1;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ========================================
    // watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
    // ========================================
    // main sequence
    initial begin
        logic [15:0] d, d2;
        int n, top, eb, com;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        reg_write(4'hf, 16'hffff);
        reg_read(4'hf, d);
        chk_val(d, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            reg_read(4'(i), d);
            chk_val(d, 16'h0000);
        end
        chk_val({12'h000, a_out, a_oe, b_out, irq}, 16'h0000);
        for (int cs = 1; cs <= 5; cs++) begin
            n = div_tab[cs - 1];
            com = (cs % 2 == 1) ? 2 : 3;
            reg_write(PFC_REG_CTRL, 16'h0000);
            reg_write(PFC_REG_STATUS, 16'h000f);
            reg_write(PFC_REG_COUNT, 16'h0000);
            reg_write(PFC_REG_CAPTOP, 16'h0003);
            reg_write(PFC_REG_CMPA, 16'h0001);
            reg_write(PFC_REG_CMPB, 16'(3 * (cs % 2)));
            reg_write(PFC_REG_PIN, 16'h0003);
            reg_write(PFC_REG_CTRL, 16'(PFC_MODE_CAPTOP) | 16'(cs << 4) | 16'(com << 8) | 16'(com << 10));
            repeat (18 * n) @(posedge core_clk);
            eb = b_edges;
            repeat (6 * n) @(posedge core_clk);
            chk_len(a_hi, com == 2 ? 2 * n : 4 * n);
            chk_len(a_lo, com == 2 ? 4 * n : 2 * n);
            chk_len(a_hi + a_lo, 6 * n);
            chk_len(b_edges - eb, 0);
            chk_val({15'h0000, b_pin}, 16'h0001);
        end
        reg_read(PFC_REG_STATUS, d);
        chk_val(d, 16'h000f);
        reg_write(PFC_REG_MASK, 16'h0000);
        @(negedge core_clk);
        chk_val({15'h0000, irq}, 16'h0000);
        reg_write(PFC_REG_MASK, 16'h0008);
        @(negedge core_clk);
        chk_val({15'h0000, irq}, 16'h0001);
        reg_write(PFC_REG_CTRL, 16'h0000);
        reg_write(PFC_REG_STATUS, 16'h000f);
        @(negedge core_clk);
        chk_val({15'h0000, irq}, 16'h0000);
        lfsr = lfsr_next(lfsr);
        top = 5 + int'(lfsr[1:0]);
        reg_write(PFC_REG_COUNT, 16'h0000);
        reg_write(PFC_REG_CMPA, 16'(top));
        reg_write(PFC_REG_CMPB, 16'h0002);
        reg_write(PFC_REG_CTRL, 16'h0819);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= PFC_REG_COUNT;
        @(posedge core_clk);
        @(negedge core_clk);
        m_cnt = int'(reg_rdata);
        m_up = 1'b1;
        for (int i = 0; i < 4 * top; i++) begin
            @(negedge core_clk);
            model_tick(top);
            chk_val(reg_rdata, 16'(m_cnt));
        end
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_read(PFC_REG_STATUS, d);
        chk_val(d, 16'h0007);
        chk_val({15'h0000, irq}, 16'h0000);
        reg_read(PFC_REG_CMPA, d);
        chk_val(d, 16'(top));
        chk_len(b_hi, 4);
        reg_write(PFC_REG_CTRL, 16'h0000);
        reg_write(PFC_REG_COUNT, 16'h0000);
        reg_write(PFC_REG_CMPA, 16'h0003);
        reg_write(PFC_REG_CTRL, 16'h0119);
        repeat (40) @(posedge core_clk);
        chk_len(a_hi, 6);
        chk_len(a_lo, 6);
        reg_write(PFC_REG_PIN, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk_val({12'h000, a_oe, b_oe, a_pin, b_pin}, 16'h0000);
        reg_write(PFC_REG_CTRL, 16'h0010);
        reg_read(PFC_REG_COUNT, d);
        repeat (5) @(posedge core_clk);
        reg_read(PFC_REG_COUNT, d2);
        chk_val(d2, d);
        final_report();
    end
endmodule // dual_slope_freq_correct_pwm_tb
